// ===== include/ptp_cfg_pkg.sv
// Purpose: Shared constants and carriers for the event and transmit
//          timestamp configuration block.
// Assumes: 16-bit management registers reached through a paged port.
// Notes:   Stream carriers are byte wide; offsets count from frame start.
package ptp_cfg_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [4:0] ADDR_PAGE_SEL = 5'h13;
   localparam logic [4:0] ADDR_EVENT_CFG = 5'h15;
   localparam logic [4:0] ADDR_TX_CFG0 = 5'h16;
   localparam logic [2:0] PAGE_PTP_CFG = 3'h5;
   localparam logic [15:0] PAGE_SEL_MASK = 16'h0007;
   localparam logic [15:0] EVENT_CFG_MASK = 16'h7f0e;
   localparam logic [15:0] TX_CFG0_MASK = 16'hbe00;
   localparam logic [15:0] RESET_VALUE = 16'h0000;

   // Event configuration field positions.
   localparam int EV_RISE_BIT = 14;
   localparam int EV_FALL_BIT = 13;
   localparam int EV_SINGLE_BIT = 12;
   localparam int EV_PIN_LSB = 8;
   localparam int EV_SEL_LSB = 1;
   localparam int EV_WR_BIT = 0;

   // Transmit configuration field positions.
   localparam int TX_SYNC_BIT = 15;
   localparam int TX_DRESP_BIT = 13;
   localparam int TX_ALT_PORT_BIT = 12;
   localparam int TX_TWOSTEP_BIT = 11;
   localparam int TX_CRC_BIT = 10;
   localparam int TX_SUM_BIT = 9;

   // ****************************************************************
   // Protocol constants
   // ****************************************************************
   localparam int NUM_UNITS = 8;
   localparam int NUM_PINS = 12;
   localparam logic [15:0] PTP_EVENT_PORT = 16'h013f;
   localparam logic [15:0] NTP_PORT = 16'h007b;
   localparam int STAMP_BYTES = 10;
   localparam int FCS_BYTES = 4;
   localparam logic [31:0] CRC_POLY = 32'hedb88320;
   localparam logic [31:0] CRC_INIT = 32'hffffffff;
   localparam logic [7:0] BYTE_ONES = 8'hff;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic rise_en;
      logic fall_en;
      logic one_shot;
      logic [3:0] pin_sel;
   } unit_cfg_t;

   typedef struct packed {
      logic valid;
      logic first;
      logic last;
      logic crc_err;
      logic [7:0] data;
   } tx_byte_t;

   typedef struct packed {
      logic is_sync;
      logic is_dreq;
      logic two_step;
      logic is_udp;
      logic [15:0] udp_port;
      logic [10:0] stamp_ofs;
      logic [10:0] sum_ofs;
      logic [10:0] fcs_ofs;
   } tx_class_t;

endpackage : ptp_cfg_pkg

// ===== rtl/event_capture_unit.sv
// Purpose: One event timestamp unit: holds its configuration and flags
//          qualified edges on its connected pin.
// Assumes: Pin level arrives already synchronous to CLK.
// Notes:   A configuration write in the same cycle as a capture wins.
`timescale 1ns/1ns
module event_capture_unit
   import ptp_cfg_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Configuration
   input wire logic wr_in,
   input wire unit_cfg_t cfg_in,
   output unit_cfg_t cfg_out,
   // Pin and capture
   input wire logic pin_in,
   output logic capture_out,
   output logic rise_out
);

   logic pin_q;
   logic fresh_q;
   unit_cfg_t cfg_q;
   unit_cfg_t cfg_d;
   wire connected = (cfg_q.pin_sel != 4'h0);
   wire rise_hit = cfg_q.rise_en & pin_in & ~pin_q;
   wire fall_hit = cfg_q.fall_en & ~pin_in & pin_q;
   // With both enables low neither hit can fire.
   // A new pin selection is compared with the old pin's sample, so the
   // cycle after a write is ignored; a real edge in that cycle is lost.
   wire hit = connected & ~fresh_q & (rise_hit | fall_hit);

   always_comb
   begin
      cfg_d = cfg_q;
      if (wr_in)
      begin
         cfg_d = cfg_in;
      end
      else if (hit && cfg_q.one_shot)
      begin
         cfg_d.rise_en = 1'b0;
         cfg_d.fall_en = 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cfg_q <= '0;
         pin_q <= 1'b0;
         fresh_q <= 1'b0;
         capture_out <= 1'b0;
         rise_out <= 1'b0;
      end
      else
      begin
         cfg_q <= cfg_d;
         pin_q <= pin_in;
         fresh_q <= wr_in;
         capture_out <= hit;
         rise_out <= hit ? rise_hit : rise_out;
      end
   end

   assign cfg_out = cfg_q;

endmodule : event_capture_unit

// ===== rtl/ptp_cfg_top.sv
// Purpose: Paged configuration registers for event timestamp units and
//          the one-step transmit timestamp path.
// Assumes: Upstream parser classifies each frame on its first byte; the
//          stream carries the incoming FCS as its final four bytes.
// Notes:   The timestamp field of a one-step frame is sent as the TX_STAMP_IN value.
`timescale 1ns/1ns

// What this block does
// - Write bit loads fields into selected unit.
// - Select without write returns unit config.
// - Bit 14 enables rising edge capture.
// - Bit 13 enables falling edge capture.
// - Single mode clears edge enables after capture.
// - Pin field 1 to 12 links unit to pin.
// - Select field picks the addressed unit.
// - Reserved bits ignore writes, read zero.
// - Sync one-step inserts transmit timestamp.
// - Inserted frames get regenerated checksum and CRC.
// - Latest Delay_Req stamp goes into Delay_Resp.
// - Port match 319, or 123 when set.
// - Bad incoming CRC stays bad unless forced.
// - Checksum fixed through last two payload bytes.
// - Event and transmit registers reachable only on page five.
module ptp_cfg_top
   import ptp_cfg_pkg::*;
(
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   // Management register port
   input wire logic [4:0] REG_ADDR_IN,
   input wire logic [15:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   output logic [15:0] REG_RDATA_OUT,
   // Event pins and captures
   input wire logic [NUM_PINS-1:0] GPIO_IN,
   output logic [NUM_UNITS-1:0] EVENT_CAPTURE_OUT,
   output logic [NUM_UNITS-1:0] EVENT_RISE_OUT,
   // Transmit stream from the MAC
   input wire tx_byte_t TX_IN,
   input wire tx_class_t TX_CLASS_IN,
   input wire logic [79:0] TX_STAMP_IN,
   output tx_byte_t TX_OUT,
   // Receive parser controls
   output logic [15:0] RX_PORT_MATCH_OUT,
   output logic RX_DRESP_INSERT_OUT,
   output logic [79:0] RX_DREQ_STAMP_OUT
);

   // ****************************************************************
   // Helper functions
   // ****************************************************************
   function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                            input logic [7:0] d);
      logic [31:0] r;
      r = c ^ {24'h000000, d};
      for (int i = 0; i < 8; i++)
      begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc_byte

   function automatic logic [15:0] add1c(input logic [15:0] a,
                                         input logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[15:0] + {15'h0000, s[16]};
   endfunction : add1c

   // Ones-complement value that cancels the stamp in the UDP sum.
   function automatic logic [15:0] stamp_fix(input logic [79:0] st);
      logic [15:0] s;
      s = 16'h0000;
      for (int i = 0; i < STAMP_BYTES / 2; i++)
      begin
         s = add1c(s, st[16*i +: 16]);
      end
      return ~s;
   endfunction : stamp_fix

   // ****************************************************************
   // Register access
   // ****************************************************************
   logic [2:0] page_q;
   logic [15:0] tx_cfg_q;
   logic [2:0] sel_q;
   logic [15:0] rdata_q;
   unit_cfg_t unit_cfg [NUM_UNITS];
   unit_cfg_t sel_cfg;

   wire on_page = (page_q == PAGE_PTP_CFG);
   wire wr_page = REG_WR_IN && (REG_ADDR_IN == ADDR_PAGE_SEL);
   wire wr_event = REG_WR_IN && on_page && (REG_ADDR_IN == ADDR_EVENT_CFG);
   wire wr_tx = REG_WR_IN && on_page && (REG_ADDR_IN == ADDR_TX_CFG0);
   wire [2:0] wsel = REG_WDATA_IN[EV_SEL_LSB +: 3];
   wire wr_unit = wr_event && REG_WDATA_IN[EV_WR_BIT];
   wire unit_cfg_t wcfg = '{rise_en: REG_WDATA_IN[EV_RISE_BIT],
                            fall_en: REG_WDATA_IN[EV_FALL_BIT],
                            one_shot: REG_WDATA_IN[EV_SINGLE_BIT],
                            pin_sel: REG_WDATA_IN[EV_PIN_LSB +: 4]};

   assign sel_cfg = unit_cfg[sel_q];

   // The write bit self-clears, so it never reads back as set.
   wire [15:0] event_rd = {1'b0, sel_cfg.rise_en, sel_cfg.fall_en,
                           sel_cfg.one_shot, sel_cfg.pin_sel, 4'h0,
                           sel_q, 1'b0};
   wire [15:0] page_rd = {13'h0000, page_q};
   wire [15:0] rd_mux =
      (REG_ADDR_IN == ADDR_PAGE_SEL) ? page_rd :
      (on_page && REG_ADDR_IN == ADDR_EVENT_CFG) ? event_rd :
      (on_page && REG_ADDR_IN == ADDR_TX_CFG0) ? tx_cfg_q : RESET_VALUE;

   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         page_q <= 3'h0;
         tx_cfg_q <= RESET_VALUE;
         sel_q <= 3'h0;
         rdata_q <= RESET_VALUE;
      end
      else
      begin
         if (wr_page)
            page_q <= REG_WDATA_IN[2:0];
         if (wr_tx)
            tx_cfg_q <= REG_WDATA_IN & TX_CFG0_MASK;
         if (wr_event)
            sel_q <= wsel;
         if (REG_RD_IN)
            rdata_q <= rd_mux;
      end
   end

   assign REG_RDATA_OUT = rdata_q;

   // ****************************************************************
   // Event timestamp units
   // ****************************************************************
   for (genvar u = 0; u < NUM_UNITS; u++)
   begin : g_unit
      wire [3:0] ps = unit_cfg[u].pin_sel;
      // Codes above twelve name no pin and leave the unit idle.
      wire pin = (ps != 4'h0 && ps <= 4'(NUM_PINS)) ?
                 GPIO_IN[ps - 4'h1] : 1'b0;
      event_capture_unit u_unit (
         .clk_in(CLK_IN),
         .rst_n_in(RST_N_IN),
         .wr_in(wr_unit && wsel == 3'(u)),
         .cfg_in(wcfg),
         .cfg_out(unit_cfg[u]),
         .pin_in(pin),
         .capture_out(EVENT_CAPTURE_OUT[u]),
         .rise_out(EVENT_RISE_OUT[u])
      );
   end

   // ****************************************************************
   // Transmit one-step insertion
   // ****************************************************************
   wire sync_en = tx_cfg_q[TX_SYNC_BIT];
   wire alt_port = tx_cfg_q[TX_ALT_PORT_BIT];
   wire two_ovr = tx_cfg_q[TX_TWOSTEP_BIT];
   wire crc_valid = tx_cfg_q[TX_CRC_BIT];
   wire sum_fix = tx_cfg_q[TX_SUM_BIT];
   wire [15:0] match_port = alt_port ? NTP_PORT : PTP_EVENT_PORT;

   logic [10:0] cnt_q;
   logic ins_q;
   logic [79:0] stamp_q;
   tx_class_t cls_q;
   logic [31:0] crc_q;
   logic [79:0] dreq_q;
   tx_byte_t out_q;

   wire first = TX_IN.valid && TX_IN.first;
   wire port_ok = !TX_CLASS_IN.is_udp ||
                  TX_CLASS_IN.udp_port == match_port;
   wire ins_new = sync_en && TX_CLASS_IN.is_sync && port_ok &&
                  (!TX_CLASS_IN.two_step || two_ovr);
   wire ins = first ? ins_new : ins_q;
   wire [79:0] stamp = first ? TX_STAMP_IN : stamp_q;
   wire tx_class_t cls = first ? TX_CLASS_IN : cls_q;
   wire [10:0] idx = first ? 11'h000 : cnt_q;
   wire [31:0] crc_cur = first ? CRC_INIT : crc_q;
   wire [10:0] st_rel = idx - cls.stamp_ofs;
   wire [10:0] fcs_rel = idx - cls.fcs_ofs;
   wire [15:0] fix = stamp_fix(stamp);
   wire in_stamp = idx >= cls.stamp_ofs &&
                   st_rel < 11'(STAMP_BYTES);
   wire in_fcs = idx >= cls.fcs_ofs && fcs_rel < 11'(FCS_BYTES);
   wire at_sum0 = sum_fix && cls.is_udp && idx == cls.sum_ofs;
   wire at_sum1 = sum_fix && cls.is_udp && idx == cls.sum_ofs + 11'h001;
   wire [31:0] fcs_val = ~crc_cur;
   // Inverting every bit of the final FCS byte guarantees a bad check.
   wire [7:0] bad_mask = (TX_IN.last && TX_IN.crc_err && !crc_valid) ?
                         BYTE_ONES : 8'h00;

   logic [7:0] body;
   logic [7:0] odata;
   always_comb
   begin
      body = TX_IN.data;
      if (ins && in_stamp)
         body = stamp[8'(79 - 8 * st_rel) -: 8];
      else if (ins && at_sum0)
         body = fix[15:8];
      else if (ins && at_sum1)
         body = fix[7:0];
      odata = body;
      if (ins && in_fcs)
         odata = fcs_val[8 * fcs_rel[1:0] +: 8] ^ bad_mask;
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         cnt_q <= 11'h000;
         ins_q <= 1'b0;
         stamp_q <= '0;
         cls_q <= '0;
         crc_q <= CRC_INIT;
         dreq_q <= '0;
         out_q <= '0;
      end
      else
      begin
         out_q <= '0;
         if (TX_IN.valid)
         begin
            cnt_q <= idx + 11'h001;
            ins_q <= ins && !TX_IN.last;
            stamp_q <= stamp;
            cls_q <= cls;
            crc_q <= in_fcs ? crc_cur : crc_byte(crc_cur, body);
            out_q <= '{valid: 1'b1, first: TX_IN.first, last: TX_IN.last,
                       crc_err: TX_IN.crc_err, data: odata};
         end
         if (first && TX_CLASS_IN.is_dreq && port_ok)
            dreq_q <= TX_STAMP_IN;
      end
   end

   assign TX_OUT = out_q;
   assign RX_PORT_MATCH_OUT = match_port;
   assign RX_DRESP_INSERT_OUT = tx_cfg_q[TX_DRESP_BIT];
   assign RX_DREQ_STAMP_OUT = dreq_q;

endmodule : ptp_cfg_top

// ===== test/mac_tx_model.sv
// Purpose: Behavioural MAC transmit side, one frame per start pulse.
// Assumes: UDP frames hold zero fillers at the two checksum fix bytes.
// Notes:   Idle data changes every cycle so stale bytes never match.
`timescale 1ns/1ns
module mac_tx_model
   import ptp_cfg_pkg::*;
#(
   parameter int LEN = 20
)
(
   // Clock and control
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic start_in,
   input wire logic two_step_in,
   input wire logic udp_in,
   input wire logic dreq_in,
   input wire logic crc_err_in,
   // Stream toward the block
   output tx_byte_t tx_out,
   output tx_class_t class_out,
   output logic [79:0] stamp_out,
   output logic busy_out
);
   // ********************
   // Frame sequencer
   // ********************
   localparam int SUM_OFS = 14;
   int idx = -1;
   logic [7:0] cyc_q = 8'h00;
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         idx <= -1;
      else if (start_in)
         idx <= 0;
      else if (idx >= 0 && idx < LEN - 1)
         idx <= idx + 1;
      else
         idx <= -1;
   end
   always_ff @(posedge clk_in)
      cyc_q <= cyc_q + 8'h01;
   assign busy_out = (idx >= 0);
   // The last four bytes stand in for the FCS.
   assign tx_out = '{valid: busy_out, first: (idx == 0),
      last: (idx == LEN - 1), crc_err: crc_err_in && (idx == LEN - 1),
      data: !busy_out ? cyc_q : (udp_in && (idx == SUM_OFS ||
      idx == SUM_OFS + 1)) ? 8'h00 : 8'(idx)};
   assign class_out = '{is_sync: !dreq_in, is_dreq: dreq_in,
      two_step: two_step_in, is_udp: udp_in, udp_port: PTP_EVENT_PORT,
      stamp_ofs: 11'h002, sum_ofs: 11'(SUM_OFS), fcs_ofs: 11'(LEN - 4)};
   assign stamp_out = 80'h0102_0304_0506_0708_090a;
endmodule : mac_tx_model

// ===== test/ptp_cfg_top_asserts.sv
// Purpose: Port-level assertions for the timestamp configuration block.
// Assumes: One clock domain, reset asynchronous and active low.
// Notes:   Tracks the page register itself to judge gated accesses.
`timescale 1ns/1ns
module ptp_cfg_checker
   import ptp_cfg_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire logic [4:0] REG_ADDR_IN,
   input wire logic [15:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   input wire logic [15:0] REG_RDATA_OUT,
   input wire logic [NUM_PINS-1:0] GPIO_IN,
   input wire logic [NUM_UNITS-1:0] EVENT_CAPTURE_OUT,
   input wire logic [NUM_UNITS-1:0] EVENT_RISE_OUT,
   input wire tx_byte_t TX_IN,
   input wire tx_byte_t TX_OUT,
   input wire logic [15:0] RX_PORT_MATCH_OUT,
   input wire logic RX_DRESP_INSERT_OUT
);
   // ********************
   // Properties
   // ********************
   logic [2:0] page_q;
   wire on_page = (page_q == PAGE_PTP_CFG);
   wire cfg_wr = REG_WR_IN && on_page && REG_ADDR_IN == ADDR_TX_CFG0;
   wire gated = REG_ADDR_IN inside {ADDR_EVENT_CFG, ADDR_TX_CFG0};
   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         page_q <= 3'h0;
      else if (REG_WR_IN && REG_ADDR_IN == ADDR_PAGE_SEL)
         page_q <= REG_WDATA_IN[2:0];
   end
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RST_N_IN);
   AST_EV_RSVD: assert property (
      REG_RD_IN && REG_ADDR_IN == ADDR_EVENT_CFG
      |=> (REG_RDATA_OUT & ~EVENT_CFG_MASK) == 16'h0000)
      else $error("Event config reserved bits read nonzero.");
   AST_TX_RSVD: assert property (
      REG_RD_IN && REG_ADDR_IN == ADDR_TX_CFG0
      |=> (REG_RDATA_OUT & ~TX_CFG0_MASK) == 16'h0000)
      else $error("Transmit config reserved bits read nonzero.");
   AST_PAGE_GATE: assert property (
      REG_RD_IN && !on_page && gated |=> REG_RDATA_OUT == 16'h0000)
      else $error("Register read off its page.");
   AST_PORT: assert property (cfg_wr |=> RX_PORT_MATCH_OUT ==
      ($past(REG_WDATA_IN[12]) ? NTP_PORT : PTP_EVENT_PORT))
      else $error("Port match wrong after write.");
   AST_DRESP: assert property (
      cfg_wr |=> RX_DRESP_INSERT_OUT == $past(REG_WDATA_IN[13]))
      else $error("Delay response insert flag wrong.");
   AST_CAP_CAUSE: assert property (
      |EVENT_CAPTURE_OUT |-> $past(GPIO_IN) != $past(GPIO_IN, 2))
      else $error("Capture without a pin edge.");
   AST_DIR_HOLD: assert property ($changed(EVENT_RISE_OUT) |->
      ((EVENT_RISE_OUT ^ $past(EVENT_RISE_OUT)) & ~EVENT_CAPTURE_OUT) == '0)
      else $error("Direction changed without capture.");
   AST_TX_LAT: assert property (TX_IN.valid |=> TX_OUT.valid &&
      TX_OUT.first == $past(TX_IN.first) && TX_OUT.last == $past(TX_IN.last))
      else $error("Transmit byte not forwarded in one cycle.");
   COV_CAP: cover property (|EVENT_CAPTURE_OUT);
   COV_TX: cover property (TX_OUT.valid && TX_OUT.last);
   COV_CFG: cover property (cfg_wr);
endmodule : ptp_cfg_checker

bind ptp_cfg_top ptp_cfg_checker u_ptp_cfg_checker (.CLK_IN, .RST_N_IN,
   .REG_ADDR_IN, .REG_WDATA_IN, .REG_WR_IN, .REG_RD_IN, .REG_RDATA_OUT,
   .GPIO_IN, .EVENT_CAPTURE_OUT, .EVENT_RISE_OUT, .TX_IN, .TX_OUT,
   .RX_PORT_MATCH_OUT, .RX_DRESP_INSERT_OUT);

// ===== test/ptp_cfg_top_bench.sv
// Purpose: Directed register, event and transmit tests of the block.
// Assumes: Inputs change 1 ns after the rising clock edge.
// Notes:   UDP frames carry zero checksum fillers at bytes 14 and 15.
`timescale 1ns/1ns
module ptp_cfg_top_bench
   import ptp_cfg_pkg::*;
;
   // ********************
   // Harness
   // ********************
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [11:0] gpio = 12'h000;
   logic start = 1'b0;
   logic two_step = 1'b0;
   logic udp = 1'b0;
   logic dreq = 1'b0;
   logic ce = 1'b0;
   logic [15:0] rdata, port;
   logic [7:0] cap, rise;
   logic dresp, busy;
   logic [79:0] stamp, dreq_stamp;
   tx_byte_t tx_in, tx_out;
   tx_class_t tx_class;
   logic [7:0] obuf [0:31];
   int oidx = 0;
   int num_errors = 0;
   int n_checks = 0;
   ptp_cfg_top u_ptp_cfg_top (.CLK_IN(clk), .RST_N_IN(rst_n),
      .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr),
      .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .GPIO_IN(gpio),
      .EVENT_CAPTURE_OUT(cap), .EVENT_RISE_OUT(rise), .TX_IN(tx_in),
      .TX_CLASS_IN(tx_class), .TX_STAMP_IN(stamp), .TX_OUT(tx_out),
      .RX_PORT_MATCH_OUT(port), .RX_DRESP_INSERT_OUT(dresp),
      .RX_DREQ_STAMP_OUT(dreq_stamp));
   mac_tx_model u_mac_tx_model (.clk_in(clk), .rst_n_in(rst_n),
      .start_in(start), .two_step_in(two_step), .udp_in(udp),
      .dreq_in(dreq), .crc_err_in(ce), .tx_out(tx_in),
      .class_out(tx_class), .stamp_out(stamp), .busy_out(busy));
   initial
   begin
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (tx_out.valid)
      begin
         obuf[tx_out.first ? 0 : oidx] <= tx_out.data;
         oidx <= tx_out.first ? 1 : oidx + 1;
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      #1;
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk);
      #1;
      wr = 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [4:0] a, input logic [15:0] e);
      @(posedge clk);
      #1;
      addr = a;
      rd = 1'b1;
      @(posedge clk);
      #1;
      rd = 1'b0;
      chk(rdata, e);
   endtask : rd_reg
   task automatic pins(input logic [11:0] v, input logic [7:0] c,
      input logic [7:0] r);
      @(posedge clk);
      #1;
      gpio = v;
      @(posedge clk);
      #1;
      chk({8'h00, cap}, {8'h00, c});
      chk({8'h00, rise}, {8'h00, r});
   endtask : pins
   // Reflected CRC-32, one bit at a time.
   function automatic logic [31:0] crc_next(input logic [31:0] c,
      input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int b = 0; b < 8; b++)
         r = (r >> 1) ^ ((r[0] ^ d[b]) ? CRC_POLY : 32'h00000000);
      return r;
   endfunction : crc_next
   // The frame body is its byte index; stamp bytes land at 2 to 11.
   task automatic frame(input logic ts, input logic u, input logic dq,
      input logic e, input logic ins, input logic fix, input logic bad);
      logic [7:0] want [0:19];
      logic [31:0] c;
      @(posedge clk);
      #1;
      two_step = ts;
      udp = u;
      dreq = dq;
      ce = e;
      start = 1'b1;
      @(posedge clk);
      #1;
      start = 1'b0;
      repeat (24) @(posedge clk);
      for (int i = 0; i < 20; i++)
         want[i] = (u && (i == 14 || i == 15)) ? 8'h00 : 8'(i);
      if (ins)
      begin
         for (int i = 2; i < 12; i++)
            want[i] = 8'(i - 1);
         // Ones-complement inverse of the stamp words 0102 to 090a.
         if (fix)
         begin
            want[14] = 8'he6;
            want[15] = 8'he1;
         end
         c = CRC_INIT;
         for (int i = 0; i < 16; i++)
            c = crc_next(c, want[i]);
         for (int i = 0; i < 4; i++)
            want[16 + i] = ~c[8 * i +: 8];
         if (bad)
            want[19] = want[19] ^ BYTE_ONES;
      end
      for (int i = 0; i < 20; i++)
         chk({8'h00, obuf[i]}, {8'h00, want[i]});
   endtask : frame
   task automatic tally_and_finish();
      $display("Checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      #20000;
      num_errors++;
      tally_and_finish();
   end
   initial
   begin
      repeat (3) @(posedge clk);
      #1;
      rst_n = 1'b1;
      chk(port, PTP_EVENT_PORT);
      wr_reg(ADDR_TX_CFG0, 16'hffff);
      rd_reg(ADDR_TX_CFG0, 16'h0000);
      wr_reg(ADDR_PAGE_SEL, 16'h0005);
      wr_reg(ADDR_TX_CFG0, 16'hffff);
      rd_reg(ADDR_TX_CFG0, TX_CFG0_MASK);
      chk(port, NTP_PORT);
      chk({15'h0000, dresp}, 16'h0001);
      $display("Test register paging done");
      wr_reg(ADDR_EVENT_CFG, 16'h4303);
      wr_reg(ADDR_EVENT_CFG, 16'h3405);
      wr_reg(ADDR_EVENT_CFG, 16'h85f7);
      wr_reg(ADDR_EVENT_CFG, 16'h0002);
      rd_reg(ADDR_EVENT_CFG, 16'h4302);
      wr_reg(ADDR_EVENT_CFG, 16'h0006);
      rd_reg(ADDR_EVENT_CFG, 16'h0506);
      pins(12'h01c, 8'h02, 8'h02);
      pins(12'h000, 8'h04, 8'h02);
      pins(12'h01c, 8'h02, 8'h02);
      pins(12'h000, 8'h00, 8'h02);
      wr_reg(ADDR_EVENT_CFG, 16'h0004);
      rd_reg(ADDR_EVENT_CFG, 16'h1404);
      $display("Test event units done");
      wr_reg(ADDR_TX_CFG0, 16'h8000);
      frame(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      frame(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      frame(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
      wr_reg(ADDR_TX_CFG0, 16'h8c00);
      frame(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
      wr_reg(ADDR_TX_CFG0, 16'h8200);
      frame(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
      wr_reg(ADDR_TX_CFG0, 16'h9200);
      frame(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      wr_reg(ADDR_TX_CFG0, 16'h0000);
      frame(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      for (int k = 0; k < 5; k++)
         chk(dreq_stamp[16 * k +: 16], stamp[16 * k +: 16]);
      frame(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      $display("Test transmit insertion done");
      tally_and_finish();
   end
endmodule : ptp_cfg_top_bench
